// >>> vie_pkg.sv
/*
 Shared constants, register map and carrier types of the vectored interrupt
 enable logic. Assumes a 32-bit APB slave port with byte addresses.
*/
package vie_pkg;

	localparam int NUM_SRC = 17;
	localparam int IDX_W   = 5;

	// Register byte addresses
	localparam logic [11:0] ADDR_ENABLE_PRIMARY   = 12'h0A8;
	localparam logic [11:0] ADDR_PRIORITY_PRIMARY = 12'h0B8;
	localparam logic [11:0] ADDR_EXT_ENABLE_ONE   = 12'h0E8;
	localparam logic [11:0] ADDR_EXT_ENABLE_TWO   = 12'h0EC;
	localparam logic [11:0] ADDR_EXT_PRIORITY_ONE = 12'h0F0;
	localparam logic [11:0] ADDR_EXT_PRIORITY_TWO = 12'h0F4;
	localparam logic [11:0] ADDR_PENDING          = 12'h100;
	localparam logic [11:0] ADDR_EXT_CONFIG       = 12'h104;
	localparam logic [11:0] ADDR_EVT_STATUS       = 12'h108;
	localparam logic [11:0] ADDR_EVT_CLEAR        = 12'h10C;
	localparam logic [11:0] ADDR_EVT_ENABLE       = 12'h110;
	localparam logic [11:0] ADDR_SERVICE_STATE    = 12'h114;

	// Fields of the primary enable register and source counts of the extended registers
	localparam int GLOBAL_IRQ_GATE_BIT = 7;
	localparam int PRIMARY_SRC_COUNT   = 7;
	localparam int EXT_ONE_SRC_COUNT   = 8;
	localparam int EXT_TWO_SRC_COUNT   = 2;

	// External line configuration fields
	localparam int CFG_EDGE_ZERO_BIT = 0;
	localparam int CFG_EDGE_ONE_BIT  = 1;
	localparam int CFG_POL_ZERO_BIT  = 2;
	localparam int CFG_POL_ONE_BIT   = 3;

	// Event status bits
	localparam int EVT_W            = 3;
	localparam int EVT_VECTOR_BIT   = 0;
	localparam int EVT_PREEMPT_BIT  = 1;
	localparam int EVT_RETURN_BIT   = 2;

	// Source order numbers with special handling
	localparam int SRC_EXT_ZERO = 0;
	localparam int SRC_EXT_ONE  = 2;
	localparam int HW_CLEARED_COUNT = 4;

	// Reset values
	localparam logic [7:0] RESET_ENABLE_PRIMARY   = 8'h00;
	localparam logic [7:0] RESET_PRIORITY_PRIMARY = 8'h80;
	localparam logic [7:0] RESET_EXT              = 8'h00;

	// Vectors
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_BASE  = 16'h0003;
	localparam logic [15:0] VECTOR_STEP  = 16'h0008;

	typedef enum logic [1:0] {
		VIE_IDLE    = 2'b00,
		VIE_LOW     = 2'b01,
		VIE_NESTED  = 2'b11,
		VIE_HIGH    = 2'b10
	} vie_service_type;

	typedef struct packed {
		logic       ext_line_zero_input;
		logic       ext_line_one_input;
		logic       timer_zero_overflow_flag;
		logic       timer_one_overflow_flag;
		logic       uart_zero_rx_done;
		logic       uart_zero_tx_done;
		logic       timer_two_low_overflow_flag;
		logic       timer_two_high_overflow_flag;
		logic       serial_periph_done_flag;
		logic       serial_periph_write_collision;
		logic       serial_periph_mode_fault;
		logic       serial_periph_rx_overrun;
		logic [9:0] other_flags;
	} vie_src_type;

	typedef struct packed {
		logic        req;
		logic        high;
		logic [15:0] vector;
	} vie_cpu_req_type;

	function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
		vector_of = VECTOR_BASE + 16'(VECTOR_STEP * 16'(idx));
	endfunction

endpackage

// >>> vie_prio_pick.sv
/*
 Fixed-order pick: the lowest set request index wins.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
module vie_prio_pick #(
	parameter int N     = 17,
	parameter int IDX_W = 5
) (
	// Requests
	input  wire logic [N-1:0]     req_i,
	// Winner
	output logic                  valid_o,
	output logic [IDX_W-1:0]      index_o
);

	function automatic logic [IDX_W-1:0] lowest_set(input logic [N-1:0] v);
		lowest_set = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (v[i])
				lowest_set = IDX_W'(i);
		end
	endfunction

	always_comb
	begin
		valid_o = |req_i;
		index_o = lowest_set(req_i);
	end

endmodule // vie_prio_pick

// >>> vie_ext_line.sv
/*
 Pending flag of one external interrupt line, edge or level sensitive with
 selectable polarity. Line input is taken as synchronous to clk_i.
*/
`timescale 1ns/1ns
module vie_ext_line (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Configuration
	input  wire logic edge_mode_i,
	input  wire logic polarity_i,
	// Line and controls
	input  wire logic line_i,
	input  wire logic ack_clear_i,
	input  wire logic sw_set_i,
	input  wire logic sw_clear_i,
	// Flag
	output logic      pending_o
);

	logic active;
	logic active_prev;
	logic edge_flag;
	logic next_active_prev;
	logic next_edge_flag;

	always_comb
	begin
		active           = polarity_i ? line_i : ~line_i;
		next_active_prev = active;
		next_edge_flag   = edge_flag;
		if (ack_clear_i || sw_clear_i)
			next_edge_flag = 1'b0;
		// A new edge in the clearing cycle is kept
		if ((active && !active_prev) || sw_set_i)
			next_edge_flag = 1'b1;
		if (!edge_mode_i)
			next_edge_flag = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			active_prev <= 1'b0;
			edge_flag   <= 1'b0;
			pending_o   <= 1'b0;
		end
		else
		begin
			active_prev <= next_active_prev;
			edge_flag   <= next_edge_flag;
			pending_o   <= edge_mode_i ? next_edge_flag : (active || sw_set_i);
		end
	end

endmodule // vie_ext_line

// >>> vie_irq_ctrl.sv
/*
 Vectored interrupt enable logic: pending collection, enable gating, two-level
 priority with fixed order, nesting state and vector hand-off to the core.
 Assumes an APB master, peripheral flags synchronous to clk_i, and a core that
 pulses cpu_ack_i when it starts the call to cpu_req_o.vector and cpu_reti_i at
 the end of each service routine.
*/
// Operation
// - Source n is served at vector 0x0003 plus 8 times n, up to 0x0083 for source 16.
// - Among pending requests of one priority level the lowest order number wins.
// - Bit 7 of the primary enable register blocks every source when clear.
// - Bit 6 gates the four serial peripheral flags.
// - Bit 5 gates the timer two request built from its low and high overflow flags.
// - Bit 4 gates the first UART request built from its receive and transmit flags.
// - Bit 3 gates the timer one overflow request.
// - Bit 2 gates external line one.
// - Bit 1 gates the timer zero overflow request.
// - Bit 0 gates external line zero.
// - Each source has one enable and one priority bit, seven in primary and ten in extended registers.
// - Pending flags set regardless of enable, and only enabled flags raise a request.
// - Only a high level request may preempt a low level routine, never an equal or higher one.
// - An edge mode external line has its pending flag cleared when the core vectors to it.
// - Peripheral flags are sampled and decoded on every clock, giving one cycle of detection; external lines take two.
`timescale 1ns/1ns
module vie_irq_ctrl (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           reset_n_i,
	// APB slave
	input  wire logic                           psel_i,
	input  wire logic                           penable_i,
	input  wire logic                           pwrite_i,
	input  wire logic [11:0]                    paddr_i,
	input  wire logic [31:0]                    pwdata_i,
	output logic [31:0]                         prdata_o,
	output logic                                pready_o,
	output logic                                pslverr_o,
	// Interrupt sources
	input  wire vie_pkg::vie_src_type           src_i,
	output logic [vie_pkg::HW_CLEARED_COUNT-1:0] hw_clear_o,
	// Core
	output vie_pkg::vie_cpu_req_type            cpu_req_o,
	input  wire logic                           cpu_ack_i,
	input  wire logic                           cpu_reti_i,
	// Event interrupt
	output logic                                evt_irq_o
);

	localparam int N = vie_pkg::NUM_SRC;
	localparam int W = vie_pkg::IDX_W;

	logic                   rst_meta;
	logic                   rst_n;
	logic [7:0]             enable_primary;
	logic [7:0]             priority_primary;
	logic [7:0]             extended_enable_one;
	logic [7:0]             extended_priority_one;
	logic [1:0]             extended_enable_two;
	logic [1:0]             extended_priority_two;
	logic [3:0]             ext_config;
	logic [N-1:0]           soft_pending;
	logic [vie_pkg::EVT_W-1:0] evt_status;
	logic [vie_pkg::EVT_W-1:0] evt_enable;
	vie_pkg::vie_service_type state;
	vie_pkg::vie_cpu_req_type  req_q;
	logic [W-1:0]           req_index;

	logic [7:0]             next_enable_primary;
	logic [7:0]             next_priority_primary;
	logic [7:0]             next_extended_enable_one;
	logic [7:0]             next_extended_priority_one;
	logic [1:0]             next_extended_enable_two;
	logic [1:0]             next_extended_priority_two;
	logic [3:0]             next_ext_config;
	logic [N-1:0]           next_soft_pending;
	logic [vie_pkg::EVT_W-1:0] next_evt_status;
	logic [vie_pkg::EVT_W-1:0] next_evt_enable;
	vie_pkg::vie_service_type next_state;
	vie_pkg::vie_cpu_req_type  next_req;
	logic [W-1:0]           next_req_index;

	logic                   wr_en;
	logic                   rd_en;
	logic                   addr_ok;
	logic                   ext_zero_pending;
	logic                   ext_one_pending;
	logic [N-1:0]           hw_pending;
	logic [N-1:0]           pending;
	logic [N-1:0]           enables;
	logic [N-1:0]           priorities;
	logic [N-1:0]           enabled_req;
	logic                   high_valid;
	logic                   low_valid;
	logic [W-1:0]           high_index;
	logic [W-1:0]           low_index;
	logic                   ack_ext_zero;
	logic                   ack_ext_one;
	logic [vie_pkg::EVT_W-1:0] evt_set;

	// Release of the asynchronous reset through two flops
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// APB decode: zero wait states, so pready is always high
	always_comb
	begin
		wr_en     = psel_i && penable_i && pwrite_i;
		rd_en     = psel_i && penable_i && !pwrite_i;
		pready_o  = 1'b1;
		case (paddr_i)
			vie_pkg::ADDR_ENABLE_PRIMARY,
			vie_pkg::ADDR_PRIORITY_PRIMARY,
			vie_pkg::ADDR_EXT_ENABLE_ONE,
			vie_pkg::ADDR_EXT_ENABLE_TWO,
			vie_pkg::ADDR_EXT_PRIORITY_ONE,
			vie_pkg::ADDR_EXT_PRIORITY_TWO,
			vie_pkg::ADDR_PENDING,
			vie_pkg::ADDR_EXT_CONFIG,
			vie_pkg::ADDR_EVT_STATUS,
			vie_pkg::ADDR_EVT_CLEAR,
			vie_pkg::ADDR_EVT_ENABLE,
			vie_pkg::ADDR_SERVICE_STATE: addr_ok = 1'b1;
			default:                     addr_ok = 1'b0;
		endcase
		pslverr_o = psel_i && penable_i && !addr_ok;
	end

	always_comb
	begin
		prdata_o = 32'h0000_0000;
		if (rd_en)
		begin
			case (paddr_i)
				vie_pkg::ADDR_ENABLE_PRIMARY:   prdata_o[7:0] = enable_primary;
				vie_pkg::ADDR_PRIORITY_PRIMARY: prdata_o[7:0] = priority_primary;
				vie_pkg::ADDR_EXT_ENABLE_ONE:   prdata_o[7:0] = extended_enable_one;
				vie_pkg::ADDR_EXT_ENABLE_TWO:   prdata_o[1:0] = extended_enable_two;
				vie_pkg::ADDR_EXT_PRIORITY_ONE: prdata_o[7:0] = extended_priority_one;
				vie_pkg::ADDR_EXT_PRIORITY_TWO: prdata_o[1:0] = extended_priority_two;
				vie_pkg::ADDR_PENDING:          prdata_o[N-1:0] = pending;
				vie_pkg::ADDR_EXT_CONFIG:       prdata_o[3:0] = ext_config;
				vie_pkg::ADDR_EVT_STATUS:       prdata_o[vie_pkg::EVT_W-1:0] = evt_status;
				vie_pkg::ADDR_EVT_ENABLE:       prdata_o[vie_pkg::EVT_W-1:0] = evt_enable;
				vie_pkg::ADDR_SERVICE_STATE:    prdata_o[1:0] = state;
				default:                        prdata_o = 32'h0000_0000;
			endcase
		end
	end

	// External lines
	assign ack_ext_zero = cpu_ack_i && req_q.req && (req_index == W'(vie_pkg::SRC_EXT_ZERO));
	assign ack_ext_one  = cpu_ack_i && req_q.req && (req_index == W'(vie_pkg::SRC_EXT_ONE));

	vie_ext_line u_ext_zero (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.edge_mode_i (ext_config[vie_pkg::CFG_EDGE_ZERO_BIT]),
		.polarity_i  (ext_config[vie_pkg::CFG_POL_ZERO_BIT]),
		.line_i      (src_i.ext_line_zero_input),
		.ack_clear_i (ack_ext_zero),
		.sw_set_i    (wr_en && paddr_i == vie_pkg::ADDR_PENDING && pwdata_i[vie_pkg::SRC_EXT_ZERO]),
		.sw_clear_i  (wr_en && paddr_i == vie_pkg::ADDR_PENDING && !pwdata_i[vie_pkg::SRC_EXT_ZERO]),
		.pending_o   (ext_zero_pending)
	);

	vie_ext_line u_ext_one (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.edge_mode_i (ext_config[vie_pkg::CFG_EDGE_ONE_BIT]),
		.polarity_i  (ext_config[vie_pkg::CFG_POL_ONE_BIT]),
		.line_i      (src_i.ext_line_one_input),
		.ack_clear_i (ack_ext_one),
		.sw_set_i    (wr_en && paddr_i == vie_pkg::ADDR_PENDING && pwdata_i[vie_pkg::SRC_EXT_ONE]),
		.sw_clear_i  (wr_en && paddr_i == vie_pkg::ADDR_PENDING && !pwdata_i[vie_pkg::SRC_EXT_ONE]),
		.pending_o   (ext_one_pending)
	);

	// Pending, enable and priority vectors in fixed order
	always_comb
	begin
		hw_pending = {src_i.other_flags,
			src_i.serial_periph_done_flag | src_i.serial_periph_write_collision |
			src_i.serial_periph_mode_fault | src_i.serial_periph_rx_overrun,
			src_i.timer_two_low_overflow_flag | src_i.timer_two_high_overflow_flag,
			src_i.uart_zero_rx_done | src_i.uart_zero_tx_done,
			src_i.timer_one_overflow_flag,
			1'b0,
			src_i.timer_zero_overflow_flag,
			1'b0};
		pending = hw_pending | soft_pending;
		pending[vie_pkg::SRC_EXT_ZERO] = ext_zero_pending;
		pending[vie_pkg::SRC_EXT_ONE]  = ext_one_pending;
		// Bits 0..6 of the primary register map to orders 0..6
		enables    = {extended_enable_two, extended_enable_one,
			enable_primary[vie_pkg::PRIMARY_SRC_COUNT-1:0]};
		priorities = {extended_priority_two, extended_priority_one,
			priority_primary[vie_pkg::PRIMARY_SRC_COUNT-1:0]};
		enabled_req = pending & enables &
			{N{enable_primary[vie_pkg::GLOBAL_IRQ_GATE_BIT]}};
	end

	vie_prio_pick #(.N(N), .IDX_W(W)) u_pick_high (
		.req_i   (enabled_req & priorities),
		.valid_o (high_valid),
		.index_o (high_index)
	);

	vie_prio_pick #(.N(N), .IDX_W(W)) u_pick_low (
		.req_i   (enabled_req & ~priorities),
		.valid_o (low_valid),
		.index_o (low_index)
	);

	// Registers, event flags and service state
	always_comb
	begin
		next_enable_primary        = enable_primary;
		next_priority_primary      = priority_primary;
		next_extended_enable_one   = extended_enable_one;
		next_extended_priority_one = extended_priority_one;
		next_extended_enable_two   = extended_enable_two;
		next_extended_priority_two = extended_priority_two;
		next_ext_config            = ext_config;
		next_soft_pending          = soft_pending;
		next_evt_enable            = evt_enable;
		next_evt_status            = evt_status;
		next_state                 = state;
		evt_set                    = '0;
		if (wr_en)
		begin
			case (paddr_i)
				vie_pkg::ADDR_ENABLE_PRIMARY:   next_enable_primary        = pwdata_i[7:0];
				vie_pkg::ADDR_PRIORITY_PRIMARY: next_priority_primary      = pwdata_i[7:0] | vie_pkg::RESET_PRIORITY_PRIMARY;
				vie_pkg::ADDR_EXT_ENABLE_ONE:   next_extended_enable_one   = pwdata_i[7:0];
				vie_pkg::ADDR_EXT_ENABLE_TWO:   next_extended_enable_two   = pwdata_i[1:0];
				vie_pkg::ADDR_EXT_PRIORITY_ONE: next_extended_priority_one = pwdata_i[7:0];
				vie_pkg::ADDR_EXT_PRIORITY_TWO: next_extended_priority_two = pwdata_i[1:0];
				vie_pkg::ADDR_PENDING:          next_soft_pending          = pwdata_i[N-1:0];
				vie_pkg::ADDR_EXT_CONFIG:       next_ext_config            = pwdata_i[3:0];
				vie_pkg::ADDR_EVT_CLEAR:        next_evt_status            = evt_status & ~pwdata_i[vie_pkg::EVT_W-1:0];
				vie_pkg::ADDR_EVT_ENABLE:       next_evt_enable            = pwdata_i[vie_pkg::EVT_W-1:0];
				default:                        next_evt_enable            = evt_enable;
			endcase
		end
		// External line bits are held in their own flag logic
		next_soft_pending[vie_pkg::SRC_EXT_ZERO] = 1'b0;
		next_soft_pending[vie_pkg::SRC_EXT_ONE]  = 1'b0;

		// Nesting: a high request may enter over a low routine only
		if (cpu_ack_i && req_q.req)
		begin
			evt_set[vie_pkg::EVT_VECTOR_BIT] = 1'b1;
			case (state)
				vie_pkg::VIE_IDLE: next_state = req_q.high ? vie_pkg::VIE_HIGH : vie_pkg::VIE_LOW;
				vie_pkg::VIE_LOW:
				begin
					next_state = vie_pkg::VIE_NESTED;
					evt_set[vie_pkg::EVT_PREEMPT_BIT] = 1'b1;
				end
				default:           next_state = state;
			endcase
		end
		else if (cpu_reti_i)
		begin
			evt_set[vie_pkg::EVT_RETURN_BIT] = 1'b1;
			case (state)
				vie_pkg::VIE_NESTED: next_state = vie_pkg::VIE_LOW;
				vie_pkg::VIE_LOW,
				vie_pkg::VIE_HIGH:   next_state = vie_pkg::VIE_IDLE;
				default:             next_state = vie_pkg::VIE_IDLE;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_evt_status = next_evt_status | evt_set;
	end

	// Request selection, registered every clock
	always_comb
	begin
		next_req       = '{req: 1'b0, high: 1'b0, vector: cpu_req_o.vector};
		next_req_index = req_index;
		if (high_valid && (state == vie_pkg::VIE_IDLE || state == vie_pkg::VIE_LOW))
		begin
			next_req       = '{req: 1'b1, high: 1'b1, vector: vie_pkg::vector_of(high_index)};
			next_req_index = high_index;
		end
		else if (low_valid && state == vie_pkg::VIE_IDLE)
		begin
			next_req       = '{req: 1'b1, high: 1'b0, vector: vie_pkg::vector_of(low_index)};
			next_req_index = low_index;
		end
		// The call in progress masks the request until the state has moved
		if (cpu_ack_i)
			next_req.req = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_primary        <= vie_pkg::RESET_ENABLE_PRIMARY;
			priority_primary      <= vie_pkg::RESET_PRIORITY_PRIMARY;
			extended_enable_one   <= vie_pkg::RESET_EXT;
			extended_priority_one <= vie_pkg::RESET_EXT;
			extended_enable_two   <= 2'h0;
			extended_priority_two <= 2'h0;
			ext_config            <= 4'h0;
			soft_pending          <= '0;
			evt_status            <= '0;
			evt_enable            <= '0;
			state                 <= vie_pkg::VIE_IDLE;
			req_q                 <= '{req: 1'b0, high: 1'b0, vector: vie_pkg::RESET_VECTOR};
			req_index             <= '0;
		end
		else
		begin
			enable_primary        <= next_enable_primary;
			priority_primary      <= next_priority_primary;
			extended_enable_one   <= next_extended_enable_one;
			extended_priority_one <= next_extended_priority_one;
			extended_enable_two   <= next_extended_enable_two;
			extended_priority_two <= next_extended_priority_two;
			ext_config            <= next_ext_config;
			soft_pending          <= next_soft_pending;
			evt_status            <= next_evt_status;
			evt_enable            <= next_evt_enable;
			state                 <= next_state;
			req_q                 <= next_req;
			req_index             <= next_req_index;
		end
	end

	always_comb
	begin
		cpu_req_o  = req_q;
		evt_irq_o  = |(evt_status & evt_enable);
		hw_clear_o = '0;
		if (cpu_ack_i && req_q.req && req_index < W'(vie_pkg::HW_CLEARED_COUNT))
			hw_clear_o[req_index[1:0]] = 1'b1;
	end

endmodule // vie_irq_ctrl

// >>> vie_irq_ctrl_checker.sv
/* Port checker of vie_irq_ctrl.
 Assumes the package register map; bound to the top module below. */
`timescale 1ns/1ns
module vie_irq_ctrl_checker (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Core and events
	input wire logic [vie_pkg::HW_CLEARED_COUNT-1:0] hw_clear_o,
	input wire vie_pkg::vie_cpu_req_type cpu_req_o,
	input wire logic cpu_ack_i,
	input wire logic evt_irq_o
);
	logic [7:0] pe;
	logic [7:0] pe_d;
	logic [2:0] ee;
	logic wr;
	assign wr = psel_i && penable_i && pwrite_i;
	// Delayed copy, because the request is registered after the enable
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pe <= 8'h00;
			pe_d <= 8'h00;
			ee <= 3'h0;
		end
		else
		begin
			pe_d <= pe;
			if (wr && paddr_i == vie_pkg::ADDR_ENABLE_PRIMARY)
				pe <= pwdata_i[7:0];
			if (wr && paddr_i == vie_pkg::ADDR_EVT_ENABLE)
				ee <= pwdata_i[2:0];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	AST_RESET_VEC: assert property ($rose(reset_n_i) |-> (!cpu_req_o.req && cpu_req_o.vector == 16'h0000) [*2])
		else $error("request not cleared by reset");
	AST_VEC_FORM: assert property (cpu_req_o.req |-> cpu_req_o.vector[2:0] == 3'h3 && cpu_req_o.vector <= 16'h0083)
		else $error("vector outside the table");
	AST_ACK_DROP: assert property (cpu_ack_i && cpu_req_o.req |=> !cpu_req_o.req)
		else $error("request kept after ack");
	AST_HW_CLR: assert property (|hw_clear_o |-> cpu_ack_i && cpu_req_o.req && cpu_req_o.vector < 16'h0020
		&& hw_clear_o == 4'(1 << cpu_req_o.vector[4:3]))
		else $error("flag clear without matching ack");
	AST_GATE: assert property (!pe_d[7] |-> !cpu_req_o.req)
		else $error("request with global gate off");
	AST_MASK: assert property (cpu_req_o.req && cpu_req_o.vector < 16'h0038 |-> pe_d[cpu_req_o.vector[5:3]])
		else $error("request from masked source");
	AST_RD_ERR: assert property (psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0 && pready_o)
		else $error("unmapped read returned data");
	AST_EVT_MASK: assert property (ee == 3'h0 |-> !evt_irq_o)
		else $error("event interrupt while masked");
	cover property (cpu_ack_i && cpu_req_o.req && cpu_req_o.high);
	cover property (|hw_clear_o);
	cover property (psel_i && penable_i && pslverr_o);
endmodule // vie_irq_ctrl_checker
bind vie_irq_ctrl vie_irq_ctrl_checker vie_irq_ctrl_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .hw_clear_o(hw_clear_o),
	.cpu_req_o(cpu_req_o), .cpu_ack_i(cpu_ack_i), .evt_irq_o(evt_irq_o));

// >>> vie_core_model.sv
/* Core model: acks a pending request while allowed.
 Assumes the request record of the package. */
`timescale 1ns/1ns
module vie_core_model (
	// Clock, reset, handshake
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ack_en_i,
	input wire vie_pkg::vie_cpu_req_type cpu_req_i,
	output logic ack_o
);
	// Stalling ack_en_i models a slow core
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ack_o <= 1'b0;
		else
			ack_o <= ack_en_i && cpu_req_i.req && !ack_o;
	end
endmodule // vie_core_model

// >>> vie_irq_ctrl_bench.sv
/* Testbench of vie_irq_ctrl.
 Assumes the core model and the bound checker. */
`timescale 1ns/1ns
module vie_irq_ctrl_bench;
	logic clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic cpu_reti_i = 1'b0, ack_en = 1'b0, pready_o, pslverr_o, err, cpu_ack_i, evt_irq_o;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [21:0] flags = 22'h0;
	logic [3:0] hw_clear_o;
	vie_pkg::vie_cpu_req_type cpu_req_o;
	int errors = 0, checks_done = 0, i, o, n;
	int ord [22] = '{0, 2, 1, 3, 4, 4, 5, 5, 6, 6, 6, 6, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7};
	vie_irq_ctrl vie_irq_ctrl_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .src_i(vie_pkg::vie_src_type'(flags)), .hw_clear_o(hw_clear_o),
		.cpu_req_o(cpu_req_o), .cpu_ack_i(cpu_ack_i), .cpu_reti_i(cpu_reti_i), .evt_irq_o(evt_irq_o));
	vie_core_model vie_core_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ack_en_i(ack_en),
		.cpu_req_i(cpu_req_o), .ack_o(cpu_ack_i));
	always #20 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic lim(input logic ok);
		if (ok !== 1'b1)
		begin
			chk(32'h0, 32'h1);
			report_and_stop();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 8);
		lim(pready_o);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// Gate is cleared first and set last, so no request slips by mid-update
	task automatic en(input logic g, input logic [16:0] m);
		apb(1'b1, vie_pkg::ADDR_ENABLE_PRIMARY, 32'({1'b0, m[6:0]}));
		apb(1'b1, vie_pkg::ADDR_EXT_ENABLE_TWO, 32'(m[16:15]));
		apb(1'b1, vie_pkg::ADDR_EXT_ENABLE_ONE, 32'(m[14:7]));
		apb(1'b1, vie_pkg::ADDR_ENABLE_PRIMARY, 32'({g, m[6:0]}));
	endtask
	task automatic wreq(output int k);
		k = 0;
		while (cpu_req_o.req !== 1'b1 && k < 8)
		begin
			@(posedge clk_i);
			k++;
		end
		lim(cpu_req_o.req);
	endtask
	task automatic take;
		int k;
		k = 0;
		ack_en <= 1'b1;
		while (cpu_req_o.req !== 1'b0 && k < 8)
		begin
			@(posedge clk_i);
			k++;
		end
		lim(!cpu_req_o.req);
		ack_en <= 1'b0;
	endtask
	task automatic noreq;
		repeat (4)
		begin
			@(posedge clk_i);
			chk(32'(cpu_req_o.req), 32'h0);
		end
	endtask
	task automatic reti;
		repeat (2) @(posedge clk_i);
		cpu_reti_i <= 1'b1;
		@(posedge clk_i);
		cpu_reti_i <= 1'b0;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(32'(cpu_req_o.vector), 32'h0);
		apb(1'b0, vie_pkg::ADDR_PRIORITY_PRIMARY, 32'h0);
		chk(rd, 32'h80);
		apb(1'b1, 12'h0FC, 32'hFF);
		chk(32'(err), 32'h1);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		$display("reset test done");
		apb(1'b1, vie_pkg::ADDR_EXT_CONFIG, 32'hC);
		for (i = 0; i < 22; i++)
		begin
			o = ord[i];
			en(1'b0, 17'h1 << o);
			flags[21 - i] <= 1'b1;
			noreq();
			apb(1'b0, vie_pkg::ADDR_PENDING, 32'h0);
			chk(32'(rd[o]), 32'h1);
			en(1'b1, 17'h0);
			noreq();
			en(1'b1, 17'h1 << o);
			wreq(n);
			chk(32'(n), 32'h2);
			chk(32'(cpu_req_o.vector), 32'h3 + 32'(o * 8));
			take();
			flags[21 - i] <= 1'b0;
			reti();
		end
		$display("source test done");
		en(1'b0, 17'h0);
		flags <= 22'h0C0000;
		apb(1'b1, vie_pkg::ADDR_PRIORITY_PRIMARY, 32'h10);
		en(1'b1, 17'h1A);
		wreq(n);
		chk(32'(cpu_req_o.vector), 32'h0B);
		take();
		flags <= 22'h0E0000;
		wreq(n);
		chk(32'(n), 32'h2);
		chk(32'({cpu_req_o.high, cpu_req_o.vector}), 32'h10023);
		take();
		apb(1'b0, vie_pkg::ADDR_SERVICE_STATE, 32'h0);
		chk(rd, 32'h3);
		flags <= 22'h040000;
		noreq();
		reti();
		reti();
		wreq(n);
		chk(32'(cpu_req_o.vector), 32'h1B);
		take();
		flags <= 22'h0;
		reti();
		$display("priority test done");
		apb(1'b1, vie_pkg::ADDR_EXT_CONFIG, 32'hD);
		en(1'b1, 17'h1);
		flags[21] <= 1'b1;
		@(posedge clk_i);
		flags[21] <= 1'b0;
		wreq(n);
		take();
		apb(1'b0, vie_pkg::ADDR_PENDING, 32'h0);
		chk(32'(rd[0]), 32'h0);
		reti();
		@(negedge clk_i);
		chk(32'(evt_irq_o), 32'h0);
		apb(1'b0, vie_pkg::ADDR_EVT_STATUS, 32'h0);
		chk(rd, 32'h7);
		apb(1'b1, vie_pkg::ADDR_EVT_ENABLE, 32'h2);
		@(negedge clk_i);
		chk(32'(evt_irq_o), 32'h1);
		apb(1'b1, vie_pkg::ADDR_EVT_CLEAR, 32'h7);
		@(negedge clk_i);
		chk(32'(evt_irq_o), 32'h0);
		apb(1'b0, vie_pkg::ADDR_EVT_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("edge and event test done");
		apb(1'b1, vie_pkg::ADDR_PENDING, 32'h1);
		wreq(n);
		reset_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(32'({cpu_req_o.req, cpu_req_o.vector}), 32'h0);
		apb(1'b0, vie_pkg::ADDR_ENABLE_PRIMARY, 32'h0);
		chk(rd, 32'h0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule // vie_irq_ctrl_bench
